// File: pkg/rsc_defs.svh
// Constants for the radio serial configuration register bank
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define RSC_WORD_BITS      24
`define RSC_TYPE_BIT       23
`define RSC_RESET_BIT      22
`define RSC_WEN_BIT        21
`define RSC_ADDR_HI        20
`define RSC_ADDR_LO        16
`define RSC_DATA_HI        15
`define RSC_INT_HI         22
`define RSC_INT_LO         20
`define RSC_FRAC_HI        19

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RSC_ADDR_CFG0      5'h00
`define RSC_ADDR_CFG1      5'h01
`define RSC_ADDR_CFG2      5'h02
`define RSC_ADDR_CFG3      5'h03
`define RSC_ADDR_CFG4      5'h04

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSC_RST_CFG0       16'h010E
`define RSC_RST_CFG1       16'h8080
`define RSC_RST_CFG2       16'h4080
`define RSC_RST_CFG3       16'h8886
`define RSC_RST_CFG4       16'hC008

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSC_CFG0_TC_HI     15
`define RSC_CFG0_TC_LO     13
`define RSC_CFG0_RATE_HI   12
`define RSC_CFG0_RATE_LO   10
`define RSC_CFG0_UWINV     9
`define RSC_CFG0_AMPGATE   8
`define RSC_CFG1_DLY_HI    15
`define RSC_CFG1_DLY_LO    12
`define RSC_CFG1_DLYEN     11
`define RSC_CFG1_AMPCUR_HI 10
`define RSC_CFG1_AMPCUR_LO 8
`define RSC_CFG1_RSSIMASK  7
`define RSC_CFG1_AMPFIRST  6
`define RSC_CFG1_EDGE      5
`define RSC_CFG1_INV       4
`define RSC_CFG1_SKIPCAL   3
`define RSC_CFG1_ERRALLOW  2
`define RSC_CFG1_REG_HI    1
`define RSC_CFG1_REG_LO    0
`define RSC_CFG3_BASE_HI   7
`define RSC_CFG3_BASE_LO   4

// ----------------------------------------
// Synthesizer arithmetic
// ----------------------------------------
`define RSC_BASE_HIGH_REF  8'h93
`define RSC_BASE_LOW_REF   8'h82
`define RSC_FREQ_MULT      30'h0000_0003
`define RSC_FRAC_BITS      20

`endif

// File: pkg/rsc_pkg.sv
// Types shared by the radio serial configuration register bank
package rsc_pkg;

  // Slicer time constant choices
  typedef enum logic [1:0]
  {
    RSC_TC_300US = 2'h0,
    RSC_TC_6US   = 2'h1,
    RSC_TC_3US   = 2'h2,
    RSC_TC_2US   = 2'h3
  } rsc_tc_t;

  // Serial shifter state
  typedef struct packed
  {
    logic [1:0]  en_sync;
    logic [1:0]  dat_sync;
    logic [1:0]  clk_sync;
    logic        clk_prev;
    logic        en_prev;
    logic [23:0] shift;
    logic [23:0] word;
    logic        word_valid;
  } rsc_shift_state_t;

  // Register bank state
  typedef struct packed
  {
    logic [1:0]  xcvr_sync;
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [15:0] cfg3;
    logic [15:0] cfg4;
    logic [2:0]  synth_int;
    logic [19:0] synth_frac;
    logic [29:0] synth_word;
    rsc_tc_t     tc_primary;
    rsc_tc_t     tc_alternate;
    logic        tc_external;
    logic        sync_detect;
    logic        rate_high_ref;
    logic        rate_valid;
    logic        amp_allowed;
    logic        rssi_enable;
    logic [3:0]  clk_delay;
    logic        reg_sel_invalid;
  } rsc_bank_state_t;

endpackage

// File: verilog/rsc_serial_shifter.sv
// Three-wire serial word shifter, sampled on the system clock
`timescale 1ns/1ns
`include "rsc_defs.svh"

module rsc_serial_shifter
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Serial bus pins
  input  wire logic        bus_enable,
  input  wire logic        bus_data,
  input  wire logic        bus_clock,
  // Captured word
  output logic [23:0]      word,
  output logic             word_valid
);

  rsc_pkg::rsc_shift_state_t s_reg;
  rsc_pkg::rsc_shift_state_t s_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_next            = s_reg;
    s_next.word_valid = 1'b0;
    s_next.en_sync    = {s_reg.en_sync[0], bus_enable};
    s_next.dat_sync   = {s_reg.dat_sync[0], bus_data};
    s_next.clk_sync   = {s_reg.clk_sync[0], bus_clock};
    s_next.clk_prev   = s_reg.clk_sync[1];
    s_next.en_prev    = s_reg.en_sync[1];
    if (!s_reg.en_sync[1] && s_reg.clk_sync[1] && !s_reg.clk_prev)
    begin
      s_next.shift = {s_reg.shift[22:0], s_reg.dat_sync[1]};
    end
    if (s_reg.en_sync[1] && !s_reg.en_prev)
    begin
      s_next.word       = s_reg.shift;
      s_next.word_valid = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_reg         <= '0;
      // Enable pin idles high: no false latch after reset
      s_reg.en_sync <= 2'h3;
      s_reg.en_prev <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign word       = s_reg.word;
  assign word_valid = s_reg.word_valid;

endmodule // rsc_serial_shifter

// File: verilog/rsc_config_regs.sv
// Serial word decoder and configuration register bank
// Notes on behaviour
// - Bit 23 of a serial word: zero is frequency word, one is configuration.
// - Frequency word bits 22:20 integer part, bits 19:0 fractional part.
// - Frequency words are accepted whether transceiver enable is low or high.
// - Channel word is three times (base offset plus integer plus fraction).
// - Base offset is field plus 147 for rates 2-4, plus 130 for 0-1.
// - Configuration word: reset bit 22, write bit 21, address 20:16, data 15:0.
// - Reset flag loads all five registers with defaults; first transfer sets it.
// - Register 0 bits 15:13 select slicer time constant and sync detect mode.
// - Register 0 bits 12:10 select bit rate and reference; codes 5-7 undefined.
// - Register 0 bit 9 inverts the sync word pattern.
// - Register 0 bit 8 blocks amplifier turn-on while synthesizer unlocked.
// - Register 1 bits 15:12 give recovered clock delay in half reference periods.
// - Register 1 bit 11 enables the recovered clock delay.
// - Register 1 bit 7 masks signal strength until tuning completes.
// - Register 1 bit 6 turns amplifier on before switch controls change.
// - Register 1 bit 5 samples transmit data on falling reference edge.
// - Register 1 bit 4 inverts transmit data before the filter.
// - Register 1 bit 3 skips oscillator recalibration, keeps IF calibration.
// - Register 1 bit 2 allows one bit error in sync word detection.
// - Register 1 bits 1:0 select regulator voltage; code 1 is invalid.
// - Serial words are shifted most significant bit first.
// - Shift data on serial clock rise while bus enable low; else ignore.
// - Bus enable rising edge loads the decoded destination register; configuration words only while transceiver enable is low.
`timescale 1ns/1ns
`include "rsc_defs.svh"

module rsc_config_regs
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Serial bus pins
  input  wire logic        bus_enable,
  input  wire logic        bus_data,
  input  wire logic        bus_clock,
  // Transceiver enable pin
  input  wire logic        transceiver_enable,
  // Internal status from radio core
  input  wire logic        synth_locked,
  input  wire logic        synth_tuning_done,
  // Raw registers
  output logic [15:0]      slicer_rate_control,
  output logic [15:0]      clock_recovery_tx_control,
  output logic [15:0]      tx_switch_timing_control,
  output logic [15:0]      synth_base_offset_control,
  output logic [15:0]      deviation_control,
  // Synthesizer programming
  output logic [2:0]       synth_integer_part,
  output logic [19:0]      synth_fraction_part,
  output logic [29:0]      synth_channel_word,
  // Slicer and rate
  output rsc_pkg::rsc_tc_t slicer_tc_primary,
  output rsc_pkg::rsc_tc_t slicer_tc_alternate,
  output logic             slicer_tc_external,
  output logic             sync_detect_mode,
  output logic [2:0]       bit_rate_select,
  output logic             rate_high_ref,
  output logic             rate_valid,
  output logic             sync_word_invert,
  output logic             sync_word_error_allow,
  // Amplifier and signal strength
  output logic             amp_lock_gate,
  output logic             amp_enable_allowed,
  output logic [2:0]       amp_current_select,
  output logic             amp_before_switch,
  output logic             signal_strength_mask,
  output logic             signal_strength_enable,
  // Clock recovery
  output logic [3:0]       recovered_clock_delay,
  output logic             recovered_clock_delay_enable,
  output logic [3:0]       recovered_clock_delay_applied,
  // Transmit path and calibration
  output logic             tx_sample_edge,
  output logic             tx_data_invert,
  output logic             skip_osc_recal,
  // Regulator
  output logic [1:0]       regulator_voltage_select,
  output logic             regulator_select_invalid
);

  logic [23:0]               word;
  logic                      word_valid;
  rsc_pkg::rsc_bank_state_t  s_reg;
  rsc_pkg::rsc_bank_state_t  s_next;

  // ----------------------------------------
  // Base offset from rate and offset field
  // ----------------------------------------
  function automatic logic [7:0] base_offset(input logic [2:0] rate, input logic [3:0] field);
    logic [7:0] add;
    add = `RSC_BASE_LOW_REF;
    if ((rate == 3'h2) || (rate == 3'h3) || (rate == 3'h4))
    begin
      add = `RSC_BASE_HIGH_REF;
    end
    base_offset = add + {4'h0, field};
  endfunction

  // ----------------------------------------
  // Serial capture
  // ----------------------------------------
  rsc_serial_shifter u_shift
  (
    .mclk       (mclk),
    .srst       (srst),
    .bus_enable (bus_enable),
    .bus_data   (bus_data),
    .bus_clock  (bus_clock),
    .word       (word),
    .word_valid (word_valid)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0]  whole;
    logic [4:0]  addr;
    logic [15:0] data;
    logic [2:0]  rate;
    whole = 8'h00;
    addr  = word[`RSC_ADDR_HI:`RSC_ADDR_LO];
    data  = word[`RSC_DATA_HI:0];
    rate  = s_reg.cfg0[`RSC_CFG0_RATE_HI:`RSC_CFG0_RATE_LO];
    s_next = s_reg;
    s_next.xcvr_sync = {s_reg.xcvr_sync[0], transceiver_enable};

    if (word_valid)
    begin
      if (!word[`RSC_TYPE_BIT])
      begin
        s_next.synth_int  = word[`RSC_INT_HI:`RSC_INT_LO];
        s_next.synth_frac = word[`RSC_FRAC_HI:0];
      end
      else if (!s_reg.xcvr_sync[1])
      begin
        if (word[`RSC_RESET_BIT])
        begin
          s_next.cfg0 = `RSC_RST_CFG0;
          s_next.cfg1 = `RSC_RST_CFG1;
          s_next.cfg2 = `RSC_RST_CFG2;
          s_next.cfg3 = `RSC_RST_CFG3;
          s_next.cfg4 = `RSC_RST_CFG4;
        end
        if (word[`RSC_WEN_BIT])
        begin
          case (addr)
            `RSC_ADDR_CFG0: s_next.cfg0 = data;
            `RSC_ADDR_CFG1: s_next.cfg1 = data;
            `RSC_ADDR_CFG2: s_next.cfg2 = data;
            `RSC_ADDR_CFG3: s_next.cfg3 = data;
            `RSC_ADDR_CFG4: s_next.cfg4 = data;
            default:        s_next.cfg0 = s_next.cfg0;
          endcase
        end
      end
    end

    whole = base_offset(rate, s_reg.cfg3[`RSC_CFG3_BASE_HI:`RSC_CFG3_BASE_LO]) + {5'h00, s_reg.synth_int};
    s_next.synth_word = 30'({whole, s_reg.synth_frac} * `RSC_FREQ_MULT);

    case (s_reg.cfg0[`RSC_CFG0_TC_HI:`RSC_CFG0_TC_LO])
      3'h0:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_300US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_300US;
        s_next.tc_external  = 1'b0;
        s_next.sync_detect  = 1'b0;
      end
      3'h1:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_6US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_6US;
        s_next.tc_external  = 1'b0;
        s_next.sync_detect  = 1'b0;
      end
      3'h2:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_3US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_3US;
        s_next.tc_external  = 1'b0;
        s_next.sync_detect  = 1'b0;
      end
      3'h3:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_2US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_2US;
        s_next.tc_external  = 1'b0;
        s_next.sync_detect  = 1'b0;
      end
      3'h4:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_300US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_6US;
        s_next.tc_external  = 1'b1;
        s_next.sync_detect  = 1'b0;
      end
      3'h5:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_300US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_3US;
        s_next.tc_external  = 1'b1;
        s_next.sync_detect  = 1'b0;
      end
      3'h6:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_6US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_6US;
        s_next.tc_external  = 1'b0;
        s_next.sync_detect  = 1'b1;
      end
      default:
      begin
        s_next.tc_primary   = rsc_pkg::RSC_TC_3US;
        s_next.tc_alternate = rsc_pkg::RSC_TC_3US;
        s_next.tc_external  = 1'b0;
        s_next.sync_detect  = 1'b1;
      end
    endcase

    s_next.rate_high_ref = (rate == 3'h0) || (rate == 3'h1);
    s_next.rate_valid    = (rate <= 3'h4);
    s_next.amp_allowed = !s_reg.cfg0[`RSC_CFG0_AMPGATE] || synth_locked;
    s_next.rssi_enable = !s_reg.cfg1[`RSC_CFG1_RSSIMASK] || synth_tuning_done;
    s_next.clk_delay = s_reg.cfg1[`RSC_CFG1_DLYEN] ? s_reg.cfg1[`RSC_CFG1_DLY_HI:`RSC_CFG1_DLY_LO] : 4'h0;
    s_next.reg_sel_invalid = (s_reg.cfg1[`RSC_CFG1_REG_HI:`RSC_CFG1_REG_LO] == 2'h1);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_reg                 <= '0;
      s_reg.cfg0            <= `RSC_RST_CFG0;
      s_reg.cfg1            <= `RSC_RST_CFG1;
      s_reg.cfg2            <= `RSC_RST_CFG2;
      s_reg.cfg3            <= `RSC_RST_CFG3;
      s_reg.cfg4            <= `RSC_RST_CFG4;
      s_reg.rate_high_ref   <= 1'b1;
      s_reg.rate_valid      <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign slicer_rate_control           = s_reg.cfg0;
  assign clock_recovery_tx_control     = s_reg.cfg1;
  assign tx_switch_timing_control      = s_reg.cfg2;
  assign synth_base_offset_control     = s_reg.cfg3;
  assign deviation_control             = s_reg.cfg4;
  assign synth_integer_part            = s_reg.synth_int;
  assign synth_fraction_part           = s_reg.synth_frac;
  assign synth_channel_word            = s_reg.synth_word;
  assign slicer_tc_primary             = s_reg.tc_primary;
  assign slicer_tc_alternate           = s_reg.tc_alternate;
  assign slicer_tc_external            = s_reg.tc_external;
  assign sync_detect_mode              = s_reg.sync_detect;
  assign bit_rate_select               = s_reg.cfg0[`RSC_CFG0_RATE_HI:`RSC_CFG0_RATE_LO];
  assign rate_high_ref                 = s_reg.rate_high_ref;
  assign rate_valid                    = s_reg.rate_valid;
  assign sync_word_invert              = s_reg.cfg0[`RSC_CFG0_UWINV];
  assign sync_word_error_allow         = s_reg.cfg1[`RSC_CFG1_ERRALLOW];
  assign amp_lock_gate                 = s_reg.cfg0[`RSC_CFG0_AMPGATE];
  assign amp_enable_allowed            = s_reg.amp_allowed;
  assign amp_current_select            = s_reg.cfg1[`RSC_CFG1_AMPCUR_HI:`RSC_CFG1_AMPCUR_LO];
  assign amp_before_switch             = s_reg.cfg1[`RSC_CFG1_AMPFIRST];
  assign signal_strength_mask          = s_reg.cfg1[`RSC_CFG1_RSSIMASK];
  assign signal_strength_enable        = s_reg.rssi_enable;
  assign recovered_clock_delay         = s_reg.cfg1[`RSC_CFG1_DLY_HI:`RSC_CFG1_DLY_LO];
  assign recovered_clock_delay_enable  = s_reg.cfg1[`RSC_CFG1_DLYEN];
  assign recovered_clock_delay_applied = s_reg.clk_delay;
  assign tx_sample_edge                = s_reg.cfg1[`RSC_CFG1_EDGE];
  assign tx_data_invert                = s_reg.cfg1[`RSC_CFG1_INV];
  assign skip_osc_recal                = s_reg.cfg1[`RSC_CFG1_SKIPCAL];
  assign regulator_voltage_select      = s_reg.cfg1[`RSC_CFG1_REG_HI:`RSC_CFG1_REG_LO];
  assign regulator_select_invalid      = s_reg.reg_sel_invalid;

endmodule // rsc_config_regs

// File: tb/rsc_config_checker.sv
// Assertion checker for the configuration register bank
`timescale 1ns/1ns

module rsc_config_checker
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Pins and status
  input wire logic        bus_enable,
  input wire logic        synth_locked,
  input wire logic        synth_tuning_done,
  // Registers
  input wire logic [15:0] slicer_rate_control,
  input wire logic [15:0] clock_recovery_tx_control,
  input wire logic [15:0] tx_switch_timing_control,
  input wire logic [15:0] synth_base_offset_control,
  input wire logic [15:0] deviation_control,
  // Derived outputs
  input wire logic [2:0]  synth_integer_part,
  input wire logic [19:0] synth_fraction_part,
  input wire logic [29:0] synth_channel_word,
  input wire logic [2:0]  bit_rate_select,
  input wire logic        rate_high_ref,
  input wire logic        rate_valid,
  input wire logic        sync_word_invert,
  input wire logic        amp_lock_gate,
  input wire logic        amp_enable_allowed,
  input wire logic        signal_strength_mask,
  input wire logic        signal_strength_enable,
  input wire logic [3:0]  recovered_clock_delay,
  input wire logic        recovered_clock_delay_enable,
  input wire logic [3:0]  recovered_clock_delay_applied,
  input wire logic [1:0]  regulator_voltage_select,
  input wire logic        regulator_select_invalid
);
  // ----------------
  // Helper logic
  // ----------------
  logic [2:0]  since_rst;
  logic [7:0]  base_h;
  logic [29:0] exp_word;

  always_ff @(posedge mclk)
    since_rst <= srst ? 3'h0 : ((since_rst == 3'h7) ? since_rst : since_rst + 3'h1);

  always_comb
  begin
    base_h   = {4'h0, synth_base_offset_control[7:4]} +
               (((bit_rate_select >= 3'h2) && (bit_rate_select <= 3'h4)) ? 8'h93 : 8'h82);
    exp_word = 30'h3 * ({2'h0, base_h + {5'h0, synth_integer_part}, 20'h0} + {10'h0, synth_fraction_part});
  end

  // ----------------
  // Assertions
  // ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_amp_gate_blocks: assert property (amp_lock_gate && !synth_locked |=> !amp_enable_allowed)
    else $error("amplifier allowed while gated and unlocked");
  a_strength_masked: assert property (signal_strength_mask && !synth_tuning_done |=> !signal_strength_enable)
    else $error("signal strength enabled while masked");
  a_rate_decode: assert property ($stable(bit_rate_select) |->
    rate_high_ref == (bit_rate_select < 3'h2) && rate_valid == (bit_rate_select < 3'h5))
    else $error("rate decode wrong");
  a_regulator_invalid: assert property ($stable(regulator_voltage_select) |->
    regulator_select_invalid == (regulator_voltage_select == 2'h1))
    else $error("regulator invalid flag wrong");
  a_delay_applied: assert property ($stable(clock_recovery_tx_control) |->
    recovered_clock_delay_applied == (recovered_clock_delay_enable ? recovered_clock_delay : 4'h0))
    else $error("applied clock delay wrong");
  a_field_map: assert property (sync_word_invert == slicer_rate_control[9] &&
    amp_lock_gate == slicer_rate_control[8] && bit_rate_select == slicer_rate_control[12:10] &&
    recovered_clock_delay == clock_recovery_tx_control[15:12])
    else $error("register field outputs misplaced");
  a_regs_hold: assert property ($stable(bus_enable) [*8] |=> $stable({slicer_rate_control,
    clock_recovery_tx_control, tx_switch_timing_control, synth_base_offset_control, deviation_control}))
    else $error("register changed without serial latch");
  a_channel_word: assert property ((since_rst == 3'h7 && $stable({synth_integer_part,
    synth_fraction_part, synth_base_offset_control, bit_rate_select})) [*2] |-> synth_channel_word == exp_word)
    else $error("channel word wrong");

  c_rate_bad: cover property (!rate_valid);
  c_reg_bad: cover property (regulator_select_invalid);
  c_amp_drop: cover property ($fell(amp_enable_allowed));
endmodule // rsc_config_checker

bind rsc_config_regs rsc_config_checker i_chk
(
  .mclk(mclk), .srst(srst), .bus_enable(bus_enable), .synth_locked(synth_locked),
  .synth_tuning_done(synth_tuning_done), .slicer_rate_control(slicer_rate_control),
  .clock_recovery_tx_control(clock_recovery_tx_control), .tx_switch_timing_control(tx_switch_timing_control),
  .synth_base_offset_control(synth_base_offset_control), .deviation_control(deviation_control),
  .synth_integer_part(synth_integer_part), .synth_fraction_part(synth_fraction_part),
  .synth_channel_word(synth_channel_word), .bit_rate_select(bit_rate_select), .rate_high_ref(rate_high_ref),
  .rate_valid(rate_valid), .sync_word_invert(sync_word_invert), .amp_lock_gate(amp_lock_gate),
  .amp_enable_allowed(amp_enable_allowed), .signal_strength_mask(signal_strength_mask),
  .signal_strength_enable(signal_strength_enable), .recovered_clock_delay(recovered_clock_delay),
  .recovered_clock_delay_enable(recovered_clock_delay_enable),
  .recovered_clock_delay_applied(recovered_clock_delay_applied),
  .regulator_voltage_select(regulator_voltage_select), .regulator_select_invalid(regulator_select_invalid)
);

// File: tb/rsc_host_model.sv
// Baseband host model driving the three-wire serial bus
`timescale 1ns/1ns

module rsc_host_model
(
  // Clock
  input  wire logic mclk,
  // Serial bus pins
  output logic      bus_enable,
  output logic      bus_data,
  output logic      bus_clock
);
  // ----------------
  // Idle levels
  // ----------------
  initial
  begin
    bus_enable = 1'b1;
    bus_data   = 1'b0;
    bus_clock  = 1'b0;
  end

  // ----------------
  // Word transfer
  // ----------------
  task automatic send_word(input logic [23:0] w, input int hold);
    @(negedge mclk);
    bus_enable <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      @(negedge mclk);
      bus_data <= w[i];
      repeat (hold) @(negedge mclk);
      bus_clock <= 1'b1;
      repeat (hold) @(negedge mclk);
      bus_clock <= 1'b0;
    end
    repeat (hold) @(negedge mclk);
    bus_enable <= 1'b1;
    @(negedge mclk);
    bus_data <= ~w[0];
  endtask
endmodule // rsc_host_model

// File: tb/tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns

module tb;
  // ----------------
  // Signals
  // ----------------
  logic              mclk, srst, xen, locked, tuned, ben, bdat, bclk;
  logic [15:0]       q0, q1, q2, q3, q4, v;
  logic [2:0]        ip, rate, apc, c;
  logic [19:0]       fp;
  logic [29:0]       cw;
  rsc_pkg::rsc_tc_t  tcp, tca;
  logic              tce, sdm, rhr, rv, swi, swe, alg, aea, abs, ssm, sse, rcde, tse, tdi, sor, rsi;
  logic [3:0]        rcd, rca;
  logic [1:0]        rvs, te;
  logic [7:0]        h;
  int                n_fail = 0;
  int                num_checks = 0;

  typedef struct packed {logic [23:0] w; logic x; logic [2:0] idx; logic [15:0] e;} rsc_row_t;
  localparam logic [15:0] DEFS [5] = '{16'h010E, 16'h8080, 16'h4080, 16'h8886, 16'hC008};
  localparam rsc_row_t ROWS [11] = '{
    '{24'hC00000, 1'b0, 3'h3, 16'h8886}, '{24'hA0817E, 1'b0, 3'h0, 16'h817E},
    '{24'hA1F482, 1'b0, 3'h1, 16'hF482}, '{24'hA24000, 1'b0, 3'h2, 16'h4000},
    '{24'hA38880, 1'b0, 3'h3, 16'h8880}, '{24'hA45200, 1'b0, 3'h4, 16'h5200},
    '{24'hA51234, 1'b0, 3'h0, 16'h817E}, '{24'h841234, 1'b0, 3'h4, 16'h5200},
    '{24'hA00000, 1'b1, 3'h0, 16'h817E}, '{24'hC00000, 1'b1, 3'h3, 16'h8880},
    '{24'hE11111, 1'b0, 3'h2, 16'h4080}};

  // ----------------
  // Clock, host and design
  // ----------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  rsc_host_model i_host (.mclk(mclk), .bus_enable(ben), .bus_data(bdat), .bus_clock(bclk));

  rsc_config_regs i_dut
  (
    .mclk(mclk), .srst(srst), .bus_enable(ben), .bus_data(bdat), .bus_clock(bclk), .transceiver_enable(xen),
    .synth_locked(locked), .synth_tuning_done(tuned), .slicer_rate_control(q0), .clock_recovery_tx_control(q1),
    .tx_switch_timing_control(q2), .synth_base_offset_control(q3), .deviation_control(q4),
    .synth_integer_part(ip), .synth_fraction_part(fp), .synth_channel_word(cw), .slicer_tc_primary(tcp),
    .slicer_tc_alternate(tca), .slicer_tc_external(tce), .sync_detect_mode(sdm), .bit_rate_select(rate),
    .rate_high_ref(rhr), .rate_valid(rv), .sync_word_invert(swi), .sync_word_error_allow(swe),
    .amp_lock_gate(alg), .amp_enable_allowed(aea), .amp_current_select(apc), .amp_before_switch(abs),
    .signal_strength_mask(ssm), .signal_strength_enable(sse), .recovered_clock_delay(rcd),
    .recovered_clock_delay_enable(rcde), .recovered_clock_delay_applied(rca), .tx_sample_edge(tse),
    .tx_data_invert(tdi), .skip_osc_recal(sor), .regulator_voltage_select(rvs), .regulator_select_invalid(rsi)
  );

  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] reg_of(input logic [2:0] idx);
    return (idx == 3'h0) ? q0 : (idx == 3'h1) ? q1 : (idx == 3'h2) ? q2 : (idx == 3'h3) ? q3 : q4;
  endfunction

  task automatic put(input logic [23:0] w, input logic x, input int hold);
    @(negedge mclk);
    xen <= x;
    i_host.send_word(w, hold);
    repeat (10) @(negedge mclk);
  endtask

  task automatic chk_defaults;
    for (int k = 0; k < 5; k++)
      chk("reg default", {16'h0, DEFS[k]}, {16'h0, reg_of(k[2:0])});
    chk("synth fields", 32'h0, {9'h0, ip, fp});
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    srst = 1'b1;
    xen = 1'b0;
    locked = 1'b0;
    tuned = 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk_defaults();
    // reset word first, register 0 next
    for (int k = 0; k < 11; k++)
    begin
      put(ROWS[k].w, ROWS[k].x, 3 + 3 * (k % 2));
      chk("reg row", {16'h0, ROWS[k].e}, {16'h0, reg_of(ROWS[k].idx)});
    end
    put(24'h5ABCDE, 1'b1, 3);
    chk("freq fields", {9'h0, 3'h5, 20'hABCDE}, {9'h0, ip, fp});
    for (int k = 0; k < 8; k++)
    begin
      c = k[2:0];
      put({8'hA0, c, c, c[0], c[1], 8'h0E}, 1'b0, 3);
      te = (c < 3'h4) ? c[1:0] : ((c[0] == 1'b0) ? 2'h1 : 2'h2);
      h = ((c >= 3'h2) && (c <= 3'h4)) ? 8'h9B : 8'h8A;
      chk("tc", {28'h0, c[2] & ~c[1], c[2] & c[1], te}, {28'h0, tce, sdm, tce ? (tcp | tca) : tcp});
      chk("rate", {27'h0, c, c < 3'h5, c < 3'h2}, {27'h0, rate, rv, rhr});
      chk("r0 bits", {29'h0, c[0], c[1], ~c[1]}, {29'h0, swi, alg, aea});
      chk("chan", 32'h3 * {4'h0, h + 8'h5, 20'hABCDE}, {2'h0, cw});
    end
    for (int k = 0; k < 4; k++)
    begin
      c = k[2:0];
      v = {4'h5, c[0], 3'h3, c[1], c[0], c[1], c[0], c[1], c[0], c[1:0]};
      put({8'hA1, v}, 1'b0, 6);
      chk("r1 fields", {16'h0, v}, {16'h0, rcd, rcde, apc, ssm, abs, tse, tdi, sor, swe, rvs});
      chk("r1 derived", {26'h0, c == 3'h1, c[0] ? 4'h5 : 4'h0, ~c[1]}, {26'h0, rsi, rca, sse});
    end
    put(24'h2ABCDE, 1'b0, 3);
    chk("freq standby", {9'h0, 3'h2, 20'hABCDE}, {9'h0, ip, fp});
    locked <= 1'b1;
    tuned <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("gates open", 32'h3, {30'h0, aea, sse});
    srst <= 1'b1;
    repeat (2) @(negedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk_defaults();
    give_verdict();
  end

  initial
  begin
    #1000000;
    n_fail++;
    give_verdict();
  end
endmodule // tb
